// ### hw/cpu_mmu_icache_defines.vh
// Constants for the translation units and instruction cache
`ifndef CPU_MMU_ICACHE_DEFINES_VH
`define CPU_MMU_ICACHE_DEFINES_VH

`define DESC_PPN      31:12
`define DESC_AP       11:10
`define DESC_DOM      8:5
`define DESC_CB       3:2
`define DESC_TYPE     1:0
`define DESC_FAULT    2'h0
`define DOM_NOACC     2'h0
`define DOM_CLIENT    2'h1
`define DOM_MANAGER   2'h3
`define AP_NONE       2'h0
`define AP_RO         2'h1
`define IC_LOCK_MAX   5'h1c
`define LINE_LAST     4'h7
`define QUEUE_FULL    2'h2

`endif

// ### hw/cpu_mmu_icache.v
// Translation units with shared table walker and instruction cache
`include "cpu_mmu_icache_defines.vh"

module cpu_mmu_icache (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        mmu_enable,
   input  wire        icache_enable,
   input  wire [31:0] table_base,
   input  wire [31:0] domain_access,
   input  wire [30:0] itb_lock,
   input  wire [30:0] dtb_lock,
   input  wire [4:0]  icache_lock_ways,
   input  wire        if_req,
   input  wire [31:0] if_addr,
   input  wire        if_dep,
   output reg         if_ack,
   output reg  [31:0] if_data,
   output reg         if_abort,
   input  wire        d_req,
   input  wire [31:0] d_addr,
   input  wire        d_write,
   output reg         d_ack,
   output reg  [31:0] d_paddr,
   output reg  [1:0]  d_attr,
   output reg         d_abort,
   output reg         mem_req,
   output reg  [31:0] mem_addr,
   output reg         mem_burst,
   input  wire        mem_rvalid,
   input  wire [31:0] mem_rdata,
   output reg         mem_rready
);

   localparam I_IDLE = 1'b0;
   localparam I_CRIT = 1'b1;
   localparam M_IDLE = 2'h0;
   localparam M_WALK = 2'h1;
   localparam M_FILL = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Storage: entries 0..31 instruction buffer, 32..63 data buffer
   reg [19:0]   tlb_vpn [0:63];
   reg [19:0]   tlb_ppn [0:63];
   reg [3:0]    tlb_dom [0:63];
   reg [1:0]    tlb_ap  [0:63];
   reg [1:0]    tlb_cb  [0:63];
   reg [63:0]   tlb_valid;
   reg [4:0]    itb_rr;
   reg [4:0]    dtb_rr;
   reg [21:0]   ic_tag  [0:1023];
   reg [32:0]   ic_data [0:8191];
   reg [1023:0] ic_valid;
   reg [4:0]    ic_rr   [0:31];

   reg          istate;
   reg [1:0]    mem_state;
   reg          walk_owner;
   reg [19:0]   walk_vpn;
   reg [5:0]    walk_ent;
   reg          fill_cache;
   reg [4:0]    fill_set;
   reg [4:0]    fill_way;
   reg [21:0]   fill_tag;
   reg [2:0]    fill_crit;
   reg [3:0]    fill_out;
   reg [31:0]   q_word  [0:1];
   reg          q_wp;
   reg          q_rp;
   reg [1:0]    q_cnt;
   integer      n;

   ////////////////////////////////////////////////////////////////////////////
   // Fully associative search; last match wins, duplicates never loaded
   function [5:0] tlb_find;
      input [31:0] hits;
      integer      j;
      reg   [5:0]  r;
      begin
         r = 6'h00;
         for (j = 0; j < 32; j = j + 1) begin
            if (hits[j])
               r = {1'b1, j[4:0]};
         end
         tlb_find = r;
      end
   endfunction

   // First unlocked slot at or after the pointer
   function [4:0] rr_pick;
      input [4:0]  ptr;
      input [31:0] lock;
      integer      k;
      reg   [5:0]  s;
      reg   [4:0]  r;
      begin
         r = ptr;
         for (k = 31; k >= 0; k = k - 1) begin
            s = {1'b0, ptr} + k[5:0];
            if (!lock[s[4:0]])
               r = s[4:0];
         end
         rr_pick = r;
      end
   endfunction

   // Domain access check against the entry permission
   function perm_fail;
      input [3:0]  dom;
      input [1:0]  ap;
      input        wr;
      input [31:0] acc;
      reg   [1:0]  dacc;
      begin
         dacc = acc[{dom, 1'b0} +: 2];
         case (dacc)
            `DOM_NOACC:   perm_fail = 1'b1;
            `DOM_CLIENT:  perm_fail = (ap == `AP_NONE) | (wr & (ap == `AP_RO));
            `DOM_MANAGER: perm_fail = 1'b0;
            default:      perm_fail = 1'b1;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Per-entry compare sits in its own process: a function that read the
   // arrays itself would not wake up when a walk loads a new entry
   reg  [63:0] tlb_hit;
   integer     e;

   always @* begin
      tlb_hit = 64'h0000_0000_0000_0000;
      for (e = 0; e < 64; e = e + 1) begin
         if (e < 32)
            tlb_hit[e] = tlb_valid[e] && (tlb_vpn[e] == if_addr[31:12]);
         else
            tlb_hit[e] = tlb_valid[e] && (tlb_vpn[e] == d_addr[31:12]);
      end
   end

   // Instruction translation
   wire [5:0]  i_find      = tlb_find(tlb_hit[31:0]);
   wire [5:0]  i_ent       = {1'b0, i_find[4:0]};
   wire        i_ready     = !mmu_enable | i_find[5];
   wire [31:0] i_pa        = mmu_enable ? {tlb_ppn[i_ent], if_addr[11:0]} : if_addr;
   wire        i_fault     = mmu_enable & perm_fail(tlb_dom[i_ent], tlb_ap[i_ent], 1'b0, domain_access);
   wire        i_cacheable = icache_enable & (!mmu_enable | tlb_cb[i_ent][1]);

   // Data translation
   wire [5:0]  d_find      = tlb_find(tlb_hit[63:32]);
   wire [5:0]  d_ent       = {1'b1, d_find[4:0]};
   wire        d_ready     = !mmu_enable | d_find[5];
   wire [31:0] d_pa        = mmu_enable ? {tlb_ppn[d_ent], d_addr[11:0]} : d_addr;
   wire        d_fault     = mmu_enable & perm_fail(tlb_dom[d_ent], tlb_ap[d_ent], d_write, domain_access);
   wire [1:0]  d_cb        = mmu_enable ? tlb_cb[d_ent] : 2'h0;

   // Victims; entry 31 has no lock bit so a victim always exists
   wire [4:0]  i_victim    = rr_pick(itb_rr, {1'b0, itb_lock});
   wire [4:0]  d_victim    = rr_pick(dtb_rr, {1'b0, dtb_lock});

   ////////////////////////////////////////////////////////////////////////////
   // Cache lookup; a parity error reads as a miss and forces a refill
   reg         ic_hit;
   reg  [4:0]  ic_way;
   reg  [31:0] ic_lockmask;
   integer     w;
   wire [4:0]  ic_locked = (icache_lock_ways > `IC_LOCK_MAX) ? `IC_LOCK_MAX : icache_lock_ways;

   always @* begin
      ic_hit = 1'b0;
      ic_way = 5'h00;
      for (w = 0; w < 32; w = w + 1) begin
         if (ic_valid[{i_pa[9:5], w[4:0]}] && ic_tag[{i_pa[9:5], w[4:0]}] == i_pa[31:10]) begin
            ic_hit = 1'b1;
            ic_way = w[4:0];
         end
         ic_lockmask[w] = (w[4:0] < ic_locked);
      end
   end

   wire [32:0] ic_word  = ic_data[{i_pa[9:5], ic_way, i_pa[4:2]}];
   wire        ic_ok    = ic_hit & ~^ic_word;
   wire [4:0]  f_victim = rr_pick(ic_rr[i_pa[9:5]], ic_lockmask);

   // Served from cache; held off while a fill is pending and the core flags a dependency
   wire        i_serve  = i_cacheable & ic_ok & !((mem_state == M_FILL) & if_dep);
   wire        i_active = (istate == I_IDLE) & if_req & !if_ack;
   wire        i_claim  = i_active & !(i_ready & (i_fault | i_serve));

   ////////////////////////////////////////////////////////////////////////////
   // Two-deep fetch queue between memory and the cache array
   wire        push        = mem_rvalid & mem_rready & (mem_state == M_FILL);
   wire        pop         = (q_cnt != 2'h0);
   wire [1:0]  next_q_cnt  = q_cnt + {1'b0, push} - {1'b0, pop};
   wire        walk_take   = mem_rvalid & mem_rready & (mem_state == M_WALK);
   wire [3:0]  fill_sum    = {1'b0, fill_crit} + fill_out;
   wire        fill_last   = fill_cache ? (fill_out == `LINE_LAST) : 1'b1;
   wire [31:0] q_head      = q_word[q_rp];

   ////////////////////////////////////////////////////////////////////////////
   // Main sequencer: walker, line fill and both request sides
   always @(posedge clk) begin
      if (sys_rst) begin
         if_ack     <= 1'b0;
         if_data    <= 32'h0000_0000;
         if_abort   <= 1'b0;
         d_ack      <= 1'b0;
         d_paddr    <= 32'h0000_0000;
         d_attr     <= 2'h0;
         d_abort    <= 1'b0;
         mem_req    <= 1'b0;
         mem_addr   <= 32'h0000_0000;
         mem_burst  <= 1'b0;
         mem_rready <= 1'b0;
         tlb_valid  <= 64'h0000_0000_0000_0000;
         ic_valid   <= {1024{1'b0}};
         itb_rr     <= 5'h00;
         dtb_rr     <= 5'h00;
         istate     <= I_IDLE;
         mem_state  <= M_IDLE;
         walk_owner <= 1'b0;
         walk_vpn   <= 20'h0_0000;
         walk_ent   <= 6'h00;
         fill_cache <= 1'b0;
         fill_set   <= 5'h00;
         fill_way   <= 5'h00;
         fill_tag   <= 22'h00_0000;
         fill_crit  <= 3'h0;
         fill_out   <= 4'h0;
         q_wp       <= 1'b0;
         q_rp       <= 1'b0;
         q_cnt      <= 2'h0;
         for (n = 0; n < 32; n = n + 1)
            ic_rr[n] <= 5'h00;
      end else begin
         if_ack     <= 1'b0;
         if_abort   <= 1'b0;
         d_ack      <= 1'b0;
         d_abort    <= 1'b0;
         mem_req    <= 1'b0;
         mem_rready <= (next_q_cnt != `QUEUE_FULL); // Back-pressure reaches memory
         q_cnt      <= next_q_cnt;

         // Queue fill from memory
         if (push) begin
            q_word[q_wp] <= mem_rdata;
            q_wp         <= ~q_wp;
         end

         // Drain: first word out is the critical word for the waiting fetch
         if (pop) begin
            q_rp     <= ~q_rp;
            fill_out <= fill_out + 4'h1;
            if (fill_cache)
               ic_data[{fill_set, fill_way, fill_sum[2:0]}] <= {^q_head, q_head};
            if (fill_out == 4'h0) begin
               if_ack  <= 1'b1;
               if_data <= q_head;
               istate  <= I_IDLE;
            end
            if (fill_last) begin
               mem_state <= M_IDLE;
               if (fill_cache) begin
                  ic_tag[{fill_set, fill_way}]   <= fill_tag;
                  ic_valid[{fill_set, fill_way}] <= 1'b1;
                  ic_rr[fill_set]                <= fill_way + 5'h01;
               end
            end
         end

         // Descriptor return; a fault descriptor aborts without loading
         if (walk_take) begin
            mem_state <= M_IDLE;
            if (mem_rdata[`DESC_TYPE] == `DESC_FAULT) begin
               if (walk_owner) begin
                  d_ack   <= 1'b1;
                  d_abort <= 1'b1;
               end else begin
                  if_ack   <= 1'b1;
                  if_abort <= 1'b1;
               end
            end else begin
               tlb_valid[walk_ent] <= 1'b1;
               tlb_vpn[walk_ent]   <= walk_vpn;
               tlb_ppn[walk_ent]   <= mem_rdata[`DESC_PPN];
               tlb_ap[walk_ent]    <= mem_rdata[`DESC_AP];
               tlb_dom[walk_ent]   <= mem_rdata[`DESC_DOM];
               tlb_cb[walk_ent]    <= mem_rdata[`DESC_CB];
               if (walk_owner)
                  dtb_rr <= walk_ent[4:0] + 5'h01;
               else
                  itb_rr <= walk_ent[4:0] + 5'h01;
            end
         end

         // Instruction side; it wins the memory port when both want it
         if (i_active) begin
            if (!i_ready) begin
               if (mem_state == M_IDLE) begin
                  mem_req    <= 1'b1;
                  mem_addr   <= {table_base[31:22], if_addr[31:12], 2'h0};
                  mem_burst  <= 1'b0;
                  mem_state  <= M_WALK;
                  walk_owner <= 1'b0;
                  walk_vpn   <= if_addr[31:12];
                  walk_ent   <= {1'b0, i_victim};
               end
            end else if (i_fault) begin
               if_ack   <= 1'b1;
               if_abort <= 1'b1;
            end else if (i_serve) begin
               if_ack  <= 1'b1;
               if_data <= ic_word[31:0];
            end else if (mem_state == M_IDLE) begin
               mem_req    <= 1'b1;
               mem_addr   <= {i_pa[31:2], 2'h0};
               mem_burst  <= i_cacheable;
               mem_state  <= M_FILL;
               istate     <= I_CRIT;
               fill_cache <= i_cacheable;
               fill_set   <= i_pa[9:5];
               fill_tag   <= i_pa[31:10];
               fill_crit  <= i_pa[4:2];
               fill_out   <= 4'h0;
               fill_way   <= f_victim;
               if (i_cacheable)
                  ic_valid[{i_pa[9:5], f_victim}] <= 1'b0; // Stale line must not hit mid-fill
            end
         end

         // Data side: translation only, answer carries physical address
         if (d_req && !d_ack) begin
            if (!d_ready) begin
               if (mem_state == M_IDLE && !i_claim) begin
                  mem_req    <= 1'b1;
                  mem_addr   <= {table_base[31:22], d_addr[31:12], 2'h0};
                  mem_burst  <= 1'b0;
                  mem_state  <= M_WALK;
                  walk_owner <= 1'b1;
                  walk_vpn   <= d_addr[31:12];
                  walk_ent   <= {1'b1, d_victim};
               end
            end else if (d_fault) begin
               d_ack   <= 1'b1;
               d_abort <= 1'b1;
            end else begin
               d_ack   <= 1'b1;
               d_paddr <= d_pa;
               d_attr  <= d_cb;
            end
         end
      end
   end

endmodule

// ### sim/cpu_mmu_icache_properties.sv
// Port checker for the translation units and instruction cache
module cpu_mmu_icache_properties (
   input logic        clk,
   input logic        sys_rst,
   input logic        mmu_enable,
   input logic        if_req,
   input logic        if_ack,
   input logic        if_abort,
   input logic        d_req,
   input logic [31:0] d_addr,
   input logic        d_ack,
   input logic [31:0] d_paddr,
   input logic [1:0]  d_attr,
   input logic        d_abort,
   input logic        mem_req,
   input logic        mem_burst
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   // Answers are single pulses tied to a pending request
   fetch_pulse_a: assert property (if_ack |=> !if_ack) else $error("fetch answer too long");
   fetch_cause_a: assert property (if_ack |-> $past(if_req)) else $error("fetch answer unasked");
   data_pulse_a: assert property (d_ack |-> $past(d_req) && !$past(d_ack)) else $error("data answer bad");
   prefetch_abort_a: assert property (if_abort |-> if_ack) else $error("abort without answer");
   data_abort_a: assert property (d_abort |-> d_ack) else $error("data abort without answer");
   // Translation off passes addresses and never aborts
   pass_through_a: assert property (d_ack && !mmu_enable && !$past(mmu_enable) |->
      d_paddr == d_addr && d_attr == 2'h0) else $error("address changed while off");
   no_check_off_a: assert property (!mmu_enable && !$past(mmu_enable) |-> !if_abort && !d_abort)
      else $error("abort while translation off");
   // Requests must finish; the bound covers a slow walk plus a fill
   fetch_bound_a: assert property ($rose(if_req) |-> ##[1:400] if_ack) else $error("fetch hung");
   data_bound_a: assert property ($rose(d_req) |-> ##[1:400] d_ack) else $error("data access hung");
   // One memory operation at a time, so no start right after another
   mem_single_a: assert property (mem_req |=> !mem_req [*2]) else $error("memory starts too close");
   cover property (if_abort);
   cover property (d_abort);
   cover property (mem_req && mem_burst);
   cover property (d_ack && !mmu_enable);
endmodule
bind cpu_mmu_icache cpu_mmu_icache_properties checker_inst (.clk(clk), .sys_rst(sys_rst),
   .mmu_enable(mmu_enable), .if_req(if_req), .if_ack(if_ack), .if_abort(if_abort), .d_req(d_req),
   .d_addr(d_addr), .d_ack(d_ack), .d_paddr(d_paddr), .d_attr(d_attr), .d_abort(d_abort),
   .mem_req(mem_req), .mem_burst(mem_burst));

// ### sim/cpu_mmu_mem_model.sv
// Memory model answering descriptor reads and line fills
module cpu_mmu_mem_model (
   input  logic        clk,
   input  logic        sys_rst,
   input  logic        slow,
   input  logic        mem_req,
   input  logic [31:0] mem_addr,
   input  logic        mem_burst,
   input  logic        mem_rready,
   output logic        mem_rvalid,
   output logic [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] addr;
   logic [3:0]  left;
   logic [2:0]  gap;
   logic [19:0] vpn;
   logic [31:0] desc;
   ////////////////////////////////////////////////////////////
   // Table sits in the top 4 MB; page bits pick access, domain and cacheability
   assign vpn = addr[21:2];
   assign desc = {vpn ^ 20'h4_0000, (vpn[5] ? 2'h1 : 2'h3), 1'b0, vpn[3:0], 1'b0, vpn[4], 1'b0,
                  (vpn[7:0] == 8'hff ? 2'h0 : 2'h2)};
   // Slow mode delays the first word and spaces the rest; idle data is inverted
   always @(posedge clk) begin
      if (sys_rst) begin
         left <= 4'h0;
         gap <= 3'h0;
         mem_rvalid <= 1'b0;
         mem_rdata <= 32'h0000_0000;
      end else if (mem_req) begin
         addr <= mem_addr;
         left <= mem_burst ? 4'h8 : 4'h1;
         gap <= slow ? 3'h5 : 3'h0;
      end else if (mem_rvalid) begin
         if (mem_rready) begin
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
            left <= left - 4'h1;
            addr[4:2] <= addr[4:2] + 3'h1; // Wraps inside the line
            gap <= slow ? 3'h2 : 3'h0;
         end
      end else if (gap != 3'h0) begin
         gap <= gap - 3'h1;
      end else if (left != 4'h0) begin
         mem_rvalid <= 1'b1;
         mem_rdata <= (addr[31:22] == 10'h3ff) ? desc : ~{addr[31:2], 2'h0};
      end
   end
endmodule

// ### sim/cpu_mmu_icache_tb.sv
// Self-checking bench for the translation units and instruction cache
module cpu_mmu_icache_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 0, sys_rst = 1, mmu_enable = 0, icache_enable = 0, slow = 0;
   logic        if_req = 0, if_dep = 0, d_req = 0, d_write = 0;
   logic [31:0] if_addr = 0, d_addr = 0, table_base = 32'hffc0_0000, domain_access = 32'hffff_fff1;
   logic [30:0] itb_lock = 0, dtb_lock = 0;
   logic [4:0]  icache_lock_ways = 5'h00;
   logic [31:0] if_data, d_paddr, mem_addr, mem_rdata;
   logic        if_ack, if_abort, d_ack, d_abort, mem_req, mem_burst, mem_rvalid, mem_rready;
   logic [1:0]  d_attr;
   int          fails = 0, checks = 0, mreqs = 0, words = 0, wseen = 0, cyc = 0;
   cpu_mmu_icache DUT (.*);
   cpu_mmu_mem_model memory (.*);
   always #12.5 clk = ~clk;
   ////////////////////////////////////////////////////////////
   // Memory traffic counts and the hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (mem_req === 1'b1) mreqs <= mreqs + 1;
      if (mem_req === 1'b1 && mem_burst === 1'b1) words <= 0;
      else if (mem_rvalid && mem_rready === 1'b1) words <= words + 1;
      if (cyc == 20000) begin
         fails++;
         complete_run;
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] phys(input logic [31:0] va);
      return mmu_enable ? {va[31:12] ^ 20'h4_0000, va[11:0]} : va;
   endfunction
   // Each access holds its request until the answer edge, then idles one cycle
   task automatic fetch(input logic [31:0] va, input logic ab);
      int n = 0;
      logic [31:0] pa = phys(va);
      if_req <= 1'b1;
      if_addr <= va;
      do @(posedge clk); while (if_ack !== 1'b1 && ++n < 400);
      wseen = words;
      if_req <= 1'b0;
      chk("fetch answer", 32'h1, {31'h0, if_ack});
      chk("prefetch abort", {31'h0, ab}, {31'h0, if_abort});
      if (!ab) chk("fetch data", ~{pa[31:2], 2'h0}, if_data);
      @(posedge clk);
   endtask
   task automatic dacc(input logic [31:0] va, input logic wr, ab, input logic [1:0] at);
      int n = 0;
      d_req <= 1'b1;
      d_addr <= va;
      d_write <= wr;
      do @(posedge clk); while (d_ack !== 1'b1 && ++n < 400);
      d_req <= 1'b0;
      chk("data answer", 32'h1, {31'h0, d_ack});
      chk("data abort", {31'h0, ab}, {31'h0, d_abort});
      if (!ab) chk("data address", phys(va), d_paddr);
      if (!ab) chk("data attributes", {30'h0, at}, {30'h0, d_attr});
      @(posedge clk);
   endtask
   task automatic t_off;
      int m = mreqs;
      dacc(32'h1234_5678, 1'b1, 1'b0, 2'h0);
      chk("walks while off", m, mreqs);
      fetch(32'h0001_2004, 1'b0);
   endtask
   task automatic t_walk;
      int m = mreqs;
      fetch(32'h0001_2014, 1'b0);
      chk("walk and fill", m + 2, mreqs);
      fetch(32'h0001_201c, 1'b0);
      chk("resident hit", m + 2, mreqs);
      dacc(32'h0001_2040, 1'b0, 1'b0, 2'h2);
      dacc(32'h0001_2080, 1'b0, 1'b0, 2'h2);
      chk("data walk once", m + 3, mreqs);
      fetch(32'h0000_2008, 1'b0);
      fetch(32'h0000_2008, 1'b0);
      chk("uncached reads", m + 6, mreqs);
   endtask
   // Slow fills leave room to fetch a cached line while the queue is busy
   task automatic t_dep;
      slow <= 1'b1;
      fetch(32'h0001_2100, 1'b0);
      fetch(32'h0001_2000, 1'b0);
      chk("hit under fill", 1, wseen < 8);
      fetch(32'h0001_2200, 1'b0);
      if_dep <= 1'b1;
      fetch(32'h0001_2004, 1'b0);
      chk("dependent waits", 8, wseen);
      if_dep <= 1'b0;
      slow <= 1'b0;
   endtask
   task automatic t_abort;
      fetch(32'h0000_1000, 1'b1);
      dacc(32'h0002_0000, 1'b0, 1'b0, 2'h0);
      dacc(32'h0002_0004, 1'b1, 1'b1, 2'h0);
      dacc(32'h000f_f000, 1'b0, 1'b1, 2'h0);
      dacc(32'h0003_1000, 1'b0, 1'b1, 2'h0);
   endtask
   // Lock count clamps to 28, so set 0 refills rotate through ways 28..31 only
   task automatic t_ways;
      int m = mreqs;
      icache_lock_ways <= 5'h1f;
      fetch(32'h0001_2400, 1'b0);
      fetch(32'h0001_2800, 1'b0);
      fetch(32'h0001_2c00, 1'b0);
      fetch(32'h0001_3000, 1'b0);
      fetch(32'h0001_3400, 1'b0);
      fetch(32'h0001_2000, 1'b0);
      fetch(32'h0001_2400, 1'b0);
      fetch(32'h0001_2c00, 1'b0);
      chk("locked cache ways", m + 7, mreqs);
      icache_lock_ways <= 5'h00;
   endtask
   // With every lockable entry held, only the last entry is ever replaced
   task automatic t_lock;
      int m = mreqs;
      dacc(32'h0004_2000, 1'b0, 1'b0, 2'h0);
      dacc(32'h0004_3000, 1'b0, 1'b0, 2'h0);
      dacc(32'h0004_2000, 1'b0, 1'b0, 2'h0);
      dacc(32'h0004_2004, 1'b0, 1'b0, 2'h0);
      chk("locked data buffer", m + 3, mreqs);
      m = mreqs;
      fetch(32'h0004_2000, 1'b0);
      fetch(32'h0004_3000, 1'b0);
      fetch(32'h0004_2000, 1'b0);
      fetch(32'h0004_2004, 1'b0);
      chk("locked fetch buffer", m + 7, mreqs);
   endtask
   task automatic complete_run;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk("idle outputs", 32'h1, {28'h0, if_ack, d_ack, mem_req, mem_rready});
      t_off;
      mmu_enable <= 1'b1;
      icache_enable <= 1'b1;
      @(posedge clk);
      t_walk;
      t_dep;
      t_abort;
      t_ways;
      dtb_lock <= '1;
      itb_lock <= '1;
      icache_enable <= 1'b0;
      @(posedge clk);
      t_lock;
      complete_run;
   end
endmodule
